// File: lim_cfg.svh
// Constants for the line input to ADC mixer routing registers.
// Assumes a register access port carrying an 8-bit address and data.
`ifndef LIM_CFG_SVH
`define LIM_CFG_SVH
`define LIM_OFS_LEFT_ROUTE   8'h15
`define LIM_OFS_RIGHT_ROUTE  8'h16
`define LIM_MODE_BIT         7
`define LIM_LEVEL_HI         6
`define LIM_LEVEL_LO         3
`define LIM_POWER_BIT        2
`define LIM_RSV_HI           2
`define LIM_STEP_OFF_BIT     1
`define LIM_LEVEL_MAX        4'h8
`define LIM_LEVEL_OFF        4'hf
`define LIM_RESET_ROUTE      8'h78
`define LIM_LEFT_WMASK       8'hf8
`endif

// File: lim_pkg.sv
// Types shared by the routing register bank.
// Assumes lim_cfg.svh is compiled with it.
`default_nettype none
package lim_pkg;
   // Register write request from the control interface.
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lim_req_t;
   // Soft-stepping pacing state.
   typedef enum logic [1:0] {
      LIM_ST_IDLE = 2'b00,
      LIM_ST_WAIT = 2'b01,
      LIM_ST_STEP = 2'b10
   } lim_step_t;
   // Whole state of the bank.
   typedef struct packed {
      logic [7:0] left_q;
      logic [7:0] right_q;
      logic [7:0] rdata_q;
      logic [3:0] left_gain_q;
      logic [3:0] right_gain_q;
      logic       left_conn_q;
      logic       right_conn_q;
      logic       fs_odd_q;
      lim_step_t  step_q;
   } lim_state_t;
endpackage : lim_pkg
`default_nettype wire

// File: lim_route_regs.sv
// Routing register bank for one line input into both ADC mixers.
// Assumes writes and the sample-rate tick arrive synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "lim_cfg.svh"
module lim_route_regs (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic       wr,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       fs_tick,
   output var  logic [7:0] rdata,
   output var  logic       left_diff,
   output var  logic       right_diff,
   output var  logic       left_conn,
   output var  logic       right_conn,
   output var  logic [3:0] left_gain,
   output var  logic [3:0] right_gain,
   output var  logic       right_adc_pwr
);
   lim_pkg::lim_state_t s_q;
   lim_pkg::lim_state_t s_d;
   lim_pkg::lim_req_t   req;
   logic [3:0]          rtgt;
   logic                pace;

   // Assertions below sample on the system clock and pause in reset.
   default clocking lim_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // A level code is a gain only up to 1000; above it is off or reserved.
   function automatic logic lvl_valid(input logic [7:0] r);
      lvl_valid = r[`LIM_LEVEL_HI:`LIM_LEVEL_LO] <= `LIM_LEVEL_MAX;
   endfunction : lvl_valid

   // Walk a gain one code toward the target.
   function automatic logic [3:0] step_to(input logic [3:0] cur,
                                          input logic [3:0] tgt);
      if (cur < tgt)
         step_to = cur + 4'h1;
      else if (cur > tgt)
         step_to = cur - 4'h1;
      else
         step_to = cur;
   endfunction : step_to

   assign req  = '{wr: wr, addr: addr, wdata: wdata};
   assign rtgt = s_q.right_q[`LIM_LEVEL_HI:`LIM_LEVEL_LO];
   // Step once per sample tick, or every second tick for mode 01.
   assign pace = fs_tick &&
                 (s_q.right_q[1:0] == 2'h0 ||
                  (s_q.right_q[1:0] == 2'h1 && s_q.fs_odd_q));

   // Next-state logic: register writes, read mux, connection and gain.
   always_comb
   begin
      s_d = s_q;
      if (req.wr && req.addr == `LIM_OFS_LEFT_ROUTE)
         s_d.left_q = req.wdata & `LIM_LEFT_WMASK;
      if (req.wr && req.addr == `LIM_OFS_RIGHT_ROUTE)
         s_d.right_q = req.wdata;
      unique case (req.addr)
         `LIM_OFS_LEFT_ROUTE:  s_d.rdata_q = s_q.left_q;
         `LIM_OFS_RIGHT_ROUTE: s_d.rdata_q = s_q.right_q;
         default:              s_d.rdata_q = 8'h00;
      endcase
      // Connection follows the level code, no separate enable.
      s_d.left_conn_q  = lvl_valid(s_q.left_q);
      s_d.right_conn_q = lvl_valid(s_q.right_q);
      s_d.left_gain_q  = s_q.left_q[`LIM_LEVEL_HI:`LIM_LEVEL_LO];
      if (fs_tick)
         s_d.fs_odd_q = !s_q.fs_odd_q;
      // Right PGA gain pacing.
      unique case (s_q.step_q)
         lim_pkg::LIM_ST_IDLE:
         begin
            if (!lvl_valid(s_q.right_q))
               s_d.right_gain_q = s_q.right_gain_q;
            else if (s_q.right_q[1])
               s_d.right_gain_q = rtgt;
            else if (s_q.right_gain_q != rtgt)
               s_d.step_q = lim_pkg::LIM_ST_WAIT;
         end
         lim_pkg::LIM_ST_WAIT:
         begin
            if (!lvl_valid(s_q.right_q) || s_q.right_q[1])
               s_d.step_q = lim_pkg::LIM_ST_IDLE;
            else if (pace)
               s_d.step_q = lim_pkg::LIM_ST_STEP;
         end
         lim_pkg::LIM_ST_STEP:
         begin
            // A reserved target written mid-walk must not be chased.
            if (lvl_valid(s_q.right_q))
               s_d.right_gain_q = step_to(s_q.right_gain_q, rtgt);
            s_d.step_q       = lim_pkg::LIM_ST_IDLE;
         end
         default: s_d.step_q = lim_pkg::LIM_ST_IDLE;
      endcase
   end

   // State register with clock enable.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q              <= '0;
         s_q.left_q       <= `LIM_RESET_ROUTE;
         s_q.right_q      <= `LIM_RESET_ROUTE;
         s_q.left_gain_q  <= `LIM_LEVEL_OFF;
         s_q.right_gain_q <= `LIM_LEVEL_MAX;
         s_q.step_q       <= lim_pkg::LIM_ST_IDLE;
      end
      else if (clk_en)
         s_q <= s_d;
   end

   // Outputs come straight from the state flip-flops.
   assign rdata         = s_q.rdata_q;
   assign left_diff     = s_q.left_q[`LIM_MODE_BIT];
   assign right_diff    = s_q.right_q[`LIM_MODE_BIT];
   assign left_conn     = s_q.left_conn_q;
   assign right_conn    = s_q.right_conn_q;
   assign left_gain     = s_q.left_gain_q;
   assign right_gain    = s_q.right_gain_q;
   assign right_adc_pwr = s_q.right_q[`LIM_POWER_BIT];

   // Left reserved bits hold zero in the register itself.
   chk_left_reserved_zero: assert property (
      s_q.left_q[`LIM_RSV_HI:0] == 3'h0)
      else $error("Left register reserved bits not zero.");
   // A left read shows zeros in the reserved bits.
   chk_left_read_zero: assert property (
      clk_en && addr == `LIM_OFS_LEFT_ROUTE |=> rdata[`LIM_RSV_HI:0] == 3'h0)
      else $error("Left read returned reserved bits set.");
   // A reserved or off left level never connects the input.
   chk_reserved_disconnects: assert property (
      clk_en && s_q.left_q[`LIM_LEVEL_HI:`LIM_LEVEL_LO] > `LIM_LEVEL_MAX
      |=> !left_conn)
      else $error("Reserved left level code connected input.");
   // Level 1111 keeps the left input off its mixer.
   chk_off_disconnects: assert property (
      clk_en && s_q.left_q[`LIM_LEVEL_HI:`LIM_LEVEL_LO] == `LIM_LEVEL_OFF
      |=> !left_conn)
      else $error("Level 1111 left input connected.");
   // A valid right level connects the input with no other enable.
   chk_valid_connects: assert property (
      clk_en && rtgt <= `LIM_LEVEL_MAX |=> right_conn)
      else $error("Valid right level did not connect.");
   // A right write lands the mode bit.
   chk_write_right_mode: assert property (
      clk_en && wr && addr == `LIM_OFS_RIGHT_ROUTE
      |=> right_diff == $past(wdata[`LIM_MODE_BIT]))
      else $error("Right mode bit not written.");
   // A right write lands the power bit.
   chk_power_write: assert property (
      clk_en && wr && addr == `LIM_OFS_RIGHT_ROUTE
      |=> right_adc_pwr == $past(wdata[`LIM_POWER_BIT]))
      else $error("Right power bit not written.");
   // The applied left gain follows the level code one edge later.
   chk_left_gain_follow: assert property (
      clk_en && wr && addr == `LIM_OFS_LEFT_ROUTE ##1 clk_en
      |=> left_gain == $past(s_q.left_q[`LIM_LEVEL_HI:`LIM_LEVEL_LO]))
      else $error("Left gain does not follow level code.");
   // With soft-stepping off, a valid target applies at once.
   chk_fast_apply: assert property (
      clk_en && s_q.step_q == lim_pkg::LIM_ST_IDLE &&
      rtgt <= `LIM_LEVEL_MAX && s_q.right_q[`LIM_STEP_OFF_BIT]
      |=> right_gain == $past(rtgt))
      else $error("Right gain not applied at once with stepping off.");
   // At once per two ticks, an even tick leaves the walk waiting.
   chk_step_paced: assert property (
      clk_en && s_q.step_q == lim_pkg::LIM_ST_WAIT && !s_q.fs_odd_q &&
      rtgt <= `LIM_LEVEL_MAX && s_q.right_q[1:0] == 2'h1
      |=> s_q.step_q == lim_pkg::LIM_ST_WAIT)
      else $error("Soft step left its wait on an even tick.");
   // At once per tick, every tick starts a step.
   chk_step_every_tick: assert property (
      clk_en && fs_tick && s_q.step_q == lim_pkg::LIM_ST_WAIT &&
      rtgt <= `LIM_LEVEL_MAX && s_q.right_q[1:0] == 2'h0
      |=> s_q.step_q == lim_pkg::LIM_ST_STEP)
      else $error("Sample tick did not start a soft step.");
   // A pending step toward a higher code.
   sequence seq_step_rise;
      clk_en && s_q.step_q == lim_pkg::LIM_ST_STEP &&
      rtgt <= `LIM_LEVEL_MAX && rtgt > s_q.right_gain_q;
   endsequence
   // A pending step toward a lower code.
   sequence seq_step_fall;
      clk_en && s_q.step_q == lim_pkg::LIM_ST_STEP &&
      rtgt <= `LIM_LEVEL_MAX && rtgt < s_q.right_gain_q;
   endsequence
   // Each step up moves exactly one code.
   chk_step_rise: assert property (
      seq_step_rise |=> right_gain == $past(right_gain) + 4'h1)
      else $error("Soft step up did not move one code.");
   // Each step down moves exactly one code.
   chk_one_step: assert property (
      seq_step_fall |=> right_gain == $past(right_gain) - 4'h1)
      else $error("Soft step down did not move one code.");
   // Soft-stepping off never starts a wait.
   chk_no_step_disabled: assert property (
      clk_en && s_q.right_q[`LIM_STEP_OFF_BIT] && right_conn &&
      s_q.step_q == lim_pkg::LIM_ST_IDLE
      |=> s_q.step_q != lim_pkg::LIM_ST_WAIT)
      else $error("Pacing started while soft-stepping disabled.");
   // A reserved or off right level freezes the right gain.
   chk_reserved_holds_gain: assert property (
      clk_en && rtgt > `LIM_LEVEL_MAX
      |=> right_gain == $past(right_gain))
      else $error("Right gain moved under a reserved level code.");
   // A low clock enable freezes every state bit.
   chk_freeze: assert property (
      !clk_en |=> s_q == $past(s_q))
      else $error("State changed while clock enable was low.");
endmodule : lim_route_regs
`default_nettype wire

// File: lim_route_regs_tb.sv
// Self-checking testbench for the line input routing register bank.
// Assumes lim_cfg.svh and lim_pkg.sv are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "lim_cfg.svh"
`define TB_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
   end end
module testbench;
   logic       sys_clk = 1'b0;
   logic       rst     = 1'b1;
   logic       clk_en  = 1'b1;
   logic       wr      = 1'b0;
   logic [7:0] addr    = 8'h00;
   logic [7:0] wdata   = 8'h00;
   logic       fs_tick = 1'b0;
   logic [7:0] rdata;
   logic       left_diff, right_diff, left_conn, right_conn, right_adc_pwr;
   logic [3:0] left_gain, right_gain;
   int         fail_count = 0;
   int         num_checks = 0;
   // Clock at 40 MHz.
   always #12.5 sys_clk = ~sys_clk;
   lim_route_regs lim_route_regs_inst (.sys_clk(sys_clk), .rst(rst),
      .clk_en(clk_en), .wr(wr), .addr(addr), .wdata(wdata),
      .fs_tick(fs_tick), .rdata(rdata), .left_diff(left_diff),
      .right_diff(right_diff), .left_conn(left_conn),
      .right_conn(right_conn), .left_gain(left_gain),
      .right_gain(right_gain), .right_adc_pwr(right_adc_pwr));
   // Waits n edges, then moves just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   // One write strobe of a single cycle.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      wr = 1'b1;
      addr = a;
      wdata = d;
      tick(1);
      wr = 1'b0;
   endtask : wr_reg
   // Reads through the registered read port and compares.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      tick(1);
      addr = a;
      tick(2);
      `TB_CHK(rdata, exp)
   endtask : rd_chk
   // Sample-rate ticks spaced well apart.
   task automatic fs(input int n);
      repeat (n)
      begin
         tick(1);
         fs_tick = 1'b1;
         tick(1);
         fs_tick = 1'b0;
         tick(4);
      end
   endtask : fs
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // Cuts a hang short.
   initial
   begin
      #50000;
      fail_count++;
      wrap_up();
   end
   // Main sequence of register accesses.
   initial
   begin
      tick(4);
      rst = 1'b0;
      rd_chk(`LIM_OFS_LEFT_ROUTE, `LIM_RESET_ROUTE);
      rd_chk(`LIM_OFS_RIGHT_ROUTE, `LIM_RESET_ROUTE);
      `TB_CHK({left_conn, right_conn, right_adc_pwr}, 3'b000)
      wr_reg(`LIM_OFS_LEFT_ROUTE, 8'hff);
      rd_chk(`LIM_OFS_LEFT_ROUTE, 8'hf8);
      `TB_CHK({left_diff, left_conn}, 2'b10)
      for (int k = 0; k <= 8; k++)
      begin
         wr_reg(`LIM_OFS_LEFT_ROUTE, {1'b1, 4'(k), 3'b000});
         tick(2);
         `TB_CHK({left_conn, left_gain}, {1'b1, 4'(k)})
      end
      // A reserved code is written on purpose to see the input stay off.
      wr_reg(`LIM_OFS_LEFT_ROUTE, 8'hc8);
      tick(2);
      `TB_CHK(left_conn, 1'b0)
      wr_reg(`LIM_OFS_RIGHT_ROUTE, 8'ha7);
      tick(4);
      `TB_CHK({right_diff, right_conn, right_adc_pwr}, 3'b111)
      `TB_CHK(right_gain, 4'h4)
      rd_chk(`LIM_OFS_RIGHT_ROUTE, 8'ha7);
      wr_reg(`LIM_OFS_RIGHT_ROUTE, 8'h80);
      tick(4);
      `TB_CHK({right_adc_pwr, right_gain}, 5'h04)
      fs(1);
      `TB_CHK(right_gain, 4'h3)
      fs(3);
      `TB_CHK(right_gain, 4'h0)
      wr_reg(`LIM_OFS_RIGHT_ROUTE, 8'h91);
      fs(2);
      `TB_CHK(right_gain, 4'h1)
      fs(2);
      `TB_CHK(right_gain, 4'h2)
      wr_reg(`LIM_OFS_RIGHT_ROUTE, 8'he8);
      tick(4);
      `TB_CHK(right_conn, 1'b0)
      `TB_CHK(right_gain, 4'h2)
      clk_en = 1'b0;
      wr_reg(`LIM_OFS_LEFT_ROUTE, 8'h00);
      clk_en = 1'b1;
      rd_chk(`LIM_OFS_LEFT_ROUTE, 8'hc8);
      rd_chk(8'h17, 8'h00);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
